// >>> include/scsd_pkg.sv
// Constants shared by the system clock source and divider block.
package scsd_pkg;
    // Register byte offsets on the AXI4-Lite slave.
    localparam logic [7:0] OFS_OUTPUT_CLK_CTRL  = 8'h00;
    localparam logic [7:0] OFS_SYSTEM_CLK_CTRL  = 8'h04;
    localparam logic [7:0] OFS_LOCAL_CLK_RATIO  = 8'h08;
    localparam logic [7:0] OFS_RESET_CFG_LOW    = 8'h0c;
    localparam logic [7:0] OFS_CLOCK_STATUS     = 8'h10;

    // Number of bus clock outputs and of modelled clock waveforms.
    localparam int NUM_BUS_OUT = 3;
    localparam int NCLK        = 13;
    localparam int CW          = 5;

    // Waveform indices.
    localparam int IX_SYNC  = 0;
    localparam int IX_BOUT  = 1;
    localparam int IX_PCIE  = 4;
    localparam int IX_SATA  = 6;
    localparam int IX_I2C1  = 8;
    localparam int IX_I2C2  = 9;
    localparam int IX_LOCAL = 10;
    localparam int IX_MEM   = 11;
    localparam int IX_MDATA = 12;

    // Unit clock mode encodings.
    localparam logic [1:0] MODE_OFF   = 2'h0;
    localparam logic [1:0] MODE_FULL  = 2'h1;
    localparam logic [1:0] MODE_HALF  = 2'h2;
    localparam logic [1:0] MODE_THIRD = 2'h3;

    // Local divider field encodings.
    localparam logic [1:0] LDIV_2 = 2'h0;
    localparam logic [1:0] LDIV_4 = 2'h1;
    localparam logic [1:0] LDIV_8 = 2'h2;

    // Half periods in base ticks; the fastest clock (twice system bus) is one tick.
    localparam logic [CW-1:0] H_OFF   = 5'h00;
    localparam logic [CW-1:0] H_REF   = 5'h01;
    localparam logic [CW-1:0] H_REF2  = 5'h02;
    localparam logic [CW-1:0] H_CSB   = 5'h02;
    localparam logic [CW-1:0] H_CSB2  = 5'h04;
    localparam logic [CW-1:0] H_CSB3  = 5'h06;
    localparam logic [CW-1:0] H_LBIU1 = 5'h02;
    localparam logic [CW-1:0] H_LBIU2 = 5'h01;
    localparam logic [CW-1:0] H_MDATA = 5'h01;

    // Reset values.
    localparam logic [NUM_BUS_OUT-1:0] RST_OUTPUT_CLK_CTRL = 3'h0;
    localparam logic [9:0]             RST_SYSTEM_CLK_CTRL = 10'h3ff;
    localparam logic [1:0]             RST_LOCAL_DIV       = 2'h0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> logic/scsd_top.sv
// System clock source selection, derived clock dividers and register slave.
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Host strap uses reference clock as primary; agent strap uses bus clock input.
// - Host mode feeds reference into halving divider and sync and bus output muxes.
// - Power-on strap selects full or halved reference on sync output.
// - Each bus clock output has an enable bit; cleared means not driven.
// - PCI Express clocks: off, full, half, third; default third of system bus.
// - SATA clocks offer off, full or third of system bus clock, no half; default third.
// - First two-wire serial clock configurable; second fixed at system bus.
// - External local clock is interface clock divided by 2, 4 or 8.
// - Local interface clock is one or two times system bus, by strap.
// - Memory data moves at twice memory bus clock rate.
// - Straps sampled during hard reset, latched at power-on release, then receivers off.
module scsd_top (
    input  wire logic                           i_ref_clk,
    input  wire logic                           i_srst,
    input  wire logic                           i_hard_reset_n,
    input  wire logic                           i_power_on_reset_n,
    input  wire logic                           i_host_strap,
    input  wire logic                           i_ref_halve_strap,
    input  wire logic                           i_local_iface_ratio_strap,
    input  wire logic                           i_bus_clock_in,
    input  wire logic [7:0]                     s_axi_awaddr,
    input  wire logic                           s_axi_awvalid,
    output logic                                s_axi_awready,
    input  wire logic [31:0]                    s_axi_wdata,
    input  wire logic [3:0]                     s_axi_wstrb,
    input  wire logic                           s_axi_wvalid,
    output logic                                s_axi_wready,
    output logic [1:0]                          s_axi_bresp,
    output logic                                s_axi_bvalid,
    input  wire logic                           s_axi_bready,
    input  wire logic [7:0]                     s_axi_araddr,
    input  wire logic                           s_axi_arvalid,
    output logic                                s_axi_arready,
    output logic [31:0]                         s_axi_rdata,
    output logic [1:0]                          s_axi_rresp,
    output logic                                s_axi_rvalid,
    input  wire logic                           s_axi_rready,
    output logic                                o_strap_receive_en,
    output logic                                o_primary_is_ref,
    output logic                                o_sync_out,
    output logic [scsd_pkg::NUM_BUS_OUT-1:0]    o_bus_clock_out_n,
    output logic [scsd_pkg::NUM_BUS_OUT-1:0]    o_bus_clock_out_drive,
    output logic [1:0]                          o_pcie_clock,
    output logic [1:0]                          o_sata_clock,
    output logic                                o_i2c1_clock,
    output logic                                o_i2c2_clock,
    output logic                                o_local_bus_clock_out,
    output logic                                o_memory_bus_clock,
    output logic                                o_memory_data_strobe
);
    import scsd_pkg::*;

    typedef struct packed {
        logic                        pins1_hr;
        logic                        pins2_hr;
        logic                        pins1_por;
        logic                        pins2_por;
        logic [2:0]                  straps1;
        logic [2:0]                  straps2;
        logic                        bclk1;
        logic                        bclk2;
        logic                        bclk3;
        logic [2:0]                  sampled;
        logic                        cfg_valid;
        logic                        cfg_host;
        logic                        cfg_halve;
        logic                        cfg_local_ratio;
        logic [NUM_BUS_OUT-1:0]      output_clock_ctrl_reg;
        logic [9:0]                  system_clock_ctrl_reg;
        logic [1:0]                  local_divider_field;
        logic [NCLK-1:0][CW-1:0]     cnt;
        logic [NCLK-1:0][CW-1:0]     cur;
        logic [NCLK-1:0]             lvl;
        logic                        aw_held;
        logic [7:0]                  aw_addr;
        logic                        w_held;
        logic [31:0]                 w_data;
        logic [3:0]                  w_strb;
        logic                        awready;
        logic                        wready;
        logic                        bvalid;
        logic [1:0]                  bresp;
        logic                        arready;
        logic                        rvalid;
        logic [31:0]                 rdata;
        logic [1:0]                  rresp;
        logic                        recv_en;
        logic [NUM_BUS_OUT-1:0]      drive;
    } scsd_state_t;

    scsd_state_t st;
    scsd_state_t next_st;

    // Half period for a unit mode; units without the halved option treat it as off.
    function automatic logic [CW-1:0] mode_half(input logic [1:0] mode, input logic allow_half);
        logic [CW-1:0] h;
        h = H_OFF;
        case (mode)
            MODE_FULL:  h = H_CSB;
            MODE_HALF:  h = allow_half ? H_CSB2 : H_OFF;
            MODE_THIRD: h = H_CSB3;
            default:    h = H_OFF;
        endcase
        return h;
    endfunction

    // Byte-lane merge of a write into a register word.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        return r;
    endfunction

    logic            tick;
    logic [CW-1:0]   req   [NCLK];
    logic [CW-1:0]   lbiu_h;
    logic [CW-1:0]   loc_h;
    logic [31:0]     wmerged;
    logic            wr_hit;

    always_comb begin
        next_st = st;
        // Two-flop synchronisers for the hard reset, power-on, strap and bus clock pins.
        next_st.pins1_hr  = i_hard_reset_n;
        next_st.pins2_hr  = st.pins1_hr;
        next_st.pins1_por = i_power_on_reset_n;
        next_st.pins2_por = st.pins1_por;
        next_st.straps1   = {i_local_iface_ratio_strap, i_ref_halve_strap, i_host_strap};
        next_st.straps2   = st.straps1;
        next_st.bclk1     = i_bus_clock_in;
        next_st.bclk2     = st.bclk1;
        next_st.bclk3     = st.bclk2;

        // Straps follow the pins while hard reset is low and freeze at power-on release.
        if (!st.pins2_hr && !st.cfg_valid) begin
            next_st.sampled = st.straps2;
        end
        if (!st.pins2_por) begin
            next_st.cfg_valid = 1'b0;
        end else if (!st.cfg_valid) begin
            next_st.cfg_valid = 1'b1;
            next_st.cfg_host  = st.sampled[0];
            next_st.cfg_halve = st.sampled[1];
            next_st.cfg_local_ratio = st.sampled[2];
        end

        // Host mode runs every cycle on the reference; agent mode steps on rising bus clock edges.
        tick = st.cfg_host ? 1'b1 : (st.bclk2 && !st.bclk3);

        for (int i = 0; i < NCLK; i++) begin
            req[i] = H_OFF;
        end
        if (st.cfg_valid) begin
            if (st.cfg_host) begin
                req[IX_SYNC] = st.cfg_halve ? H_REF2 : H_REF;
                for (int i = 0; i < NUM_BUS_OUT; i++) begin
                    req[IX_BOUT + i] = st.output_clock_ctrl_reg[i] ? req[IX_SYNC] : H_OFF;
                end
            end
            for (int i = 0; i < 2; i++) begin
                req[IX_PCIE + i] = mode_half(st.system_clock_ctrl_reg[2*i +: 2], 1'b1);
                req[IX_SATA + i] = mode_half(st.system_clock_ctrl_reg[4 + 2*i +: 2], 1'b0);
            end
            req[IX_I2C1] = mode_half(st.system_clock_ctrl_reg[9:8], 1'b1);
            req[IX_I2C2] = H_CSB;
            req[IX_LOCAL] = loc_h;
            req[IX_MEM]   = H_CSB;
            req[IX_MDATA] = H_MDATA;
        end

        // Changes take effect only at the end of a low phase, so no runt pulse can appear.
        if (tick) begin
            for (int i = 0; i < NCLK; i++) begin
                if (st.cur[i] == H_OFF) begin
                    next_st.cnt[i] = '0;
                    next_st.lvl[i] = (req[i] != H_OFF);
                    next_st.cur[i] = req[i];
                end else if (st.cnt[i] + 5'h01 >= st.cur[i]) begin
                    next_st.cnt[i] = '0;
                    if (st.lvl[i]) begin
                        next_st.lvl[i] = 1'b0;
                    end else begin
                        next_st.cur[i] = req[i];
                        next_st.lvl[i] = (req[i] != H_OFF);
                    end
                end else begin
                    next_st.cnt[i] = st.cnt[i] + 5'h01;
                end
            end
        end

        // AXI4-Lite write: address and data taken in either order, response after both.
        wmerged = 32'h0;
        wr_hit  = 1'b1;
        if (s_axi_awvalid && st.awready) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
            next_st.awready = 1'b0;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.w_held = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
            next_st.wready = 1'b0;
        end
        if (st.aw_held && st.w_held && !st.bvalid) begin
            case (st.aw_addr)
                OFS_OUTPUT_CLK_CTRL: begin
                    wmerged = merge({29'h0, st.output_clock_ctrl_reg}, st.w_data, st.w_strb);
                    next_st.output_clock_ctrl_reg = wmerged[NUM_BUS_OUT-1:0];
                end
                OFS_SYSTEM_CLK_CTRL: begin
                    wmerged = merge({22'h0, st.system_clock_ctrl_reg}, st.w_data, st.w_strb);
                    next_st.system_clock_ctrl_reg = wmerged[9:0];
                end
                OFS_LOCAL_CLK_RATIO: begin
                    wmerged = merge({30'h0, st.local_divider_field}, st.w_data, st.w_strb);
                    next_st.local_divider_field = wmerged[1:0];
                end
                OFS_RESET_CFG_LOW, OFS_CLOCK_STATUS: begin
                    wr_hit = 1'b1;
                end
                default: begin
                    wr_hit = 1'b0;
                end
            endcase
            next_st.bvalid  = 1'b1;
            next_st.bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
            next_st.aw_held = 1'b0;
            next_st.w_held  = 1'b0;
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid  = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready  = 1'b1;
        end

        // AXI4-Lite read: one outstanding read, answered the cycle after the address.
        if (s_axi_arvalid && st.arready) begin
            next_st.arready = 1'b0;
            next_st.rvalid  = 1'b1;
            next_st.rresp   = RESP_OKAY;
            case (s_axi_araddr)
                OFS_OUTPUT_CLK_CTRL: next_st.rdata = {29'h0, st.output_clock_ctrl_reg};
                OFS_SYSTEM_CLK_CTRL: next_st.rdata = {22'h0, st.system_clock_ctrl_reg};
                OFS_LOCAL_CLK_RATIO: next_st.rdata = {30'h0, st.local_divider_field};
                OFS_RESET_CFG_LOW:   next_st.rdata = {28'h0, st.cfg_valid, st.cfg_local_ratio, st.cfg_halve, st.cfg_host};
                OFS_CLOCK_STATUS:    next_st.rdata = {19'h0, st.lvl};
                default: begin
                    next_st.rdata = 32'h0;
                    next_st.rresp = RESP_SLVERR;
                end
            endcase
        end
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid  = 1'b0;
            next_st.arready = 1'b1;
        end

        if (i_srst) begin
            next_st                       = '0;
            next_st.pins1_hr              = 1'b0;
            next_st.output_clock_ctrl_reg = RST_OUTPUT_CLK_CTRL;
            next_st.system_clock_ctrl_reg = RST_SYSTEM_CLK_CTRL;
            next_st.local_divider_field   = RST_LOCAL_DIV;
            next_st.awready               = 1'b1;
            next_st.wready                = 1'b1;
            next_st.arready               = 1'b1;
        end

        // Both pin controls come from flops so no decode glitch can reach the pins.
        next_st.recv_en = !next_st.cfg_valid;
        next_st.drive   = next_st.output_clock_ctrl_reg & {NUM_BUS_OUT{next_st.cfg_host & next_st.cfg_valid}};
    end

    // Local interface clock from the ratio strap, then the external divider.
    always_comb begin
        lbiu_h = st.cfg_local_ratio ? H_LBIU2 : H_LBIU1;
        case (st.local_divider_field)
            LDIV_2:  loc_h = CW'(lbiu_h * 2);
            LDIV_4:  loc_h = CW'(lbiu_h * 4);
            LDIV_8:  loc_h = CW'(lbiu_h * 8);
            default: loc_h = CW'(lbiu_h * 8);
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        st <= next_st;
    end

    assign s_axi_awready         = st.awready;
    assign s_axi_wready          = st.wready;
    assign s_axi_bvalid          = st.bvalid;
    assign s_axi_bresp           = st.bresp;
    assign s_axi_arready         = st.arready;
    assign s_axi_rvalid          = st.rvalid;
    assign s_axi_rdata           = st.rdata;
    assign s_axi_rresp           = st.rresp;
    assign o_strap_receive_en    = st.recv_en;
    assign o_primary_is_ref      = st.cfg_host;
    assign o_sync_out            = st.lvl[IX_SYNC];
    assign o_bus_clock_out_n     = st.lvl[IX_BOUT +: NUM_BUS_OUT];
    assign o_bus_clock_out_drive = st.drive;
    assign o_pcie_clock          = st.lvl[IX_PCIE +: 2];
    assign o_sata_clock          = st.lvl[IX_SATA +: 2];
    assign o_i2c1_clock          = st.lvl[IX_I2C1];
    assign o_i2c2_clock          = st.lvl[IX_I2C2];
    assign o_local_bus_clock_out = st.lvl[IX_LOCAL];
    assign o_memory_bus_clock    = st.lvl[IX_MEM];
    assign o_memory_data_strobe  = st.lvl[IX_MDATA];

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);

    host_sync_full_a: assert property (st.cfg_valid && st.cfg_host && !st.cfg_halve && st.lvl[IX_SYNC]
        ##1 st.cfg_valid && st.cfg_host && !st.cfg_halve |-> !st.lvl[IX_SYNC])
        else $error("Full-rate sync output did not toggle.");
    sync_halved_a: assert property (st.cfg_host && st.cfg_halve && st.cur[IX_SYNC] == H_REF2
        && $rose(st.lvl[IX_SYNC]) |=> st.lvl[IX_SYNC])
        else $error("Halved sync output high phase too short.");
    bus_out_off_a: assert property (st.cur[IX_BOUT] == H_OFF |-> !st.lvl[IX_BOUT])
        else $error("Disabled bus clock output is high.");
    agent_no_sync_a: assert property (st.cfg_valid && !st.cfg_host && $stable(st.cfg_host)
        && st.cur[IX_SYNC] == H_OFF |=> !st.lvl[IX_SYNC])
        else $error("Sync output active in agent mode.");
    pcie_third_a: assert property (st.cur[IX_PCIE] == H_CSB3 && st.cfg_host && $rose(st.lvl[IX_PCIE])
        |-> st.lvl[IX_PCIE] [*6] ##1 !st.lvl[IX_PCIE])
        else $error("Third-rate unit clock high phase not six ticks.");
    sata_no_half_a: assert property (st.cur[IX_SATA] != H_CSB2)
        else $error("SATA clock running at half rate.");
    i2c2_fixed_a: assert property (st.cur[IX_I2C2] == H_OFF || st.cur[IX_I2C2] == H_CSB)
        else $error("Second serial clock not at system bus rate.");
    no_runt_a: assert property ($fell(st.lvl[IX_LOCAL]) && st.cfg_host |-> $past(st.cnt[IX_LOCAL]) + 5'h01
        >= $past(st.cur[IX_LOCAL]))
        else $error("Local clock high phase cut short.");
    local_div_a: assert property (st.cur[IX_LOCAL] != H_OFF |-> st.cur[IX_LOCAL] >= 5'h02)
        else $error("Local clock faster than interface clock halved.");
    mem_rate_a: assert property (st.cfg_host && st.cur[IX_MEM] == H_CSB && st.cur[IX_MDATA] == H_MDATA
        && $rose(st.lvl[IX_MEM]) |-> ##2 $fell(st.lvl[IX_MEM]))
        else $error("Memory clock period not twice data strobe period.");
    strap_freeze_a: assert property (st.cfg_valid && $stable(st.cfg_valid) |-> $stable(st.cfg_host))
        else $error("Latched strap changed after power-on release.");
    bresp_pair_a: assert property (st.aw_held && st.w_held && !st.bvalid |=> st.bvalid)
        else $error("Write response not raised after address and data.");

    host_run_c:  cover property (st.cfg_valid && st.cfg_host && st.lvl[IX_BOUT]);
    agent_run_c: cover property (st.cfg_valid && !st.cfg_host && st.lvl[IX_PCIE]);
    div8_c:      cover property (st.cur[IX_LOCAL] == 5'h10 && st.lvl[IX_LOCAL]);
endmodule
`default_nettype wire

// >>> bench/scsd_pci_partner.sv
// Bus clock source that stands in for the PCI bus when the block is an agent.
`timescale 1ns/1ps
`default_nettype none
module scsd_pci_partner #(
    parameter int HALF_NS = 120
) (
    input  wire logic i_run,
    output logic      o_bus_clock
);
    // The clock stands low outside a run, as a stopped bus clock would.
    // A small offset keeps its edges away from the block clock edges.
    always begin
        o_bus_clock = 1'b0;
        wait (i_run);
        #3;
        while (i_run) begin
            #HALF_NS o_bus_clock = ~o_bus_clock;
        end
    end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench for the clock source and divider block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import scsd_pkg::*;
    logic clk = 0, srst = 1, hrst_n = 0, por_n = 0, host = 1, halve = 1, lratio = 0, run = 0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, recv_en, prim, sync, i2c1, i2c2, loc_clk, mclk, mstb, bus_clk;
    logic [1:0] bresp, rresp, pcie, sata;
    logic [2:0] bco, bdrv;
    int fail_count = 0, checked = 0;
    wire logic [12:0] waves = {mstb, mclk, loc_clk, i2c2, i2c1, sata, pcie, bco, sync};
    always #20 clk = ~clk;
    scsd_pci_partner partner (.i_run(run), .o_bus_clock(bus_clk));
    scsd_top dut (.i_ref_clk(clk), .i_srst(srst), .i_hard_reset_n(hrst_n), .i_power_on_reset_n(por_n),
        .i_host_strap(host), .i_ref_halve_strap(halve), .i_local_iface_ratio_strap(lratio),
        .i_bus_clock_in(bus_clk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .o_strap_receive_en(recv_en), .o_primary_is_ref(prim),
        .o_sync_out(sync), .o_bus_clock_out_n(bco), .o_bus_clock_out_drive(bdrv), .o_pcie_clock(pcie),
        .o_sata_clock(sata), .o_i2c1_clock(i2c1), .o_i2c2_clock(i2c2), .o_local_bus_clock_out(loc_clk),
        .o_memory_bus_clock(mclk), .o_memory_data_strobe(mstb));
    task automatic tally_and_finish();
        if (fail_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t %s got %0h exp %0h", $time, m, g, e);
        end
    endtask
    task automatic give_up(input string m);
        cmp(32'h0, 32'h1, m);
        tally_and_finish();
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        if (n == 50) give_up("write hang");
        cmp(32'(bresp), 32'(RESP_OKAY), "bresp");
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        if (n == 50) give_up("read hang");
        cmp(rdata, e, "rdata");
        cmp(32'(rresp), 32'(er), "rresp");
        rready <= 1'b0;
    endtask
    // The first rise after a setting change may still carry the old phase, so the
    // period is taken between the second and third rises.
    task automatic chk_period(input int ix, input int e);
        int n, r, t;
        logic p;
        r = 0;
        t = 0;
        p = waves[ix];
        for (n = 0; n < 400 && r < 3; n++) begin
            @(posedge clk);
            if (waves[ix] === 1'b1 && p === 1'b0) begin
                r++;
                if (r == 2) t = n;
            end
            p = waves[ix];
        end
        if (r < 3) give_up("no clock");
        cmp(n - 1 - t, e, "period");
    endtask
    task automatic chk_low(input int ix);
        repeat (40) begin
            @(posedge clk);
            cmp(32'(waves[ix]), 32'h0, "clock off");
        end
    endtask
    task automatic do_reset(input logic h, input logic hv, input logic lr);
        int n;
        @(posedge clk);
        srst <= 1'b1; hrst_n <= 1'b0; por_n <= 1'b0; host <= h; halve <= hv; lratio <= lr; run <= !h;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        cmp(32'(recv_en), 32'h1, "receivers");
        hrst_n <= 1'b1;
        por_n <= 1'b1;
        for (n = 0; n < 20 && recv_en !== 1'b0; n++) @(posedge clk);
        if (n == 20) give_up("no latch");
        host <= !h;
        repeat (4) @(posedge clk);
        cmp(32'(prim), 32'(h), "primary");
        host <= h;
    endtask
    task automatic sc_host_defaults();
        do_reset(1'b1, 1'b1, 1'b0);
        axi_rd(OFS_SYSTEM_CLK_CTRL, 32'h3ff, RESP_OKAY);
        axi_rd(OFS_RESET_CFG_LOW, 32'hb, RESP_OKAY);
        axi_rd(OFS_LOCAL_CLK_RATIO, 32'h0, RESP_OKAY);
        axi_rd(8'h40, 32'h0, RESP_SLVERR);
        chk_period(IX_SYNC, 4);
        chk_period(IX_PCIE + 1, 12);
        chk_period(IX_SATA, 12);
        chk_period(IX_I2C1, 12);
        chk_period(IX_I2C2, 4);
        chk_period(IX_MEM, 4);
        chk_period(IX_MDATA, 2);
        chk_period(IX_LOCAL, 8);
    endtask
    task automatic sc_unit_modes();
        axi_wr(OFS_SYSTEM_CLK_CTRL, 32'h149);
        chk_period(IX_PCIE, 4);
        chk_period(IX_PCIE + 1, 8);
        chk_period(IX_SATA + 1, 4);
        chk_period(IX_I2C1, 4);
        chk_period(IX_I2C2, 4);
        chk_low(IX_SATA);
        axi_wr(OFS_LOCAL_CLK_RATIO, 32'h1);
        chk_period(IX_LOCAL, 16);
        axi_wr(OFS_LOCAL_CLK_RATIO, 32'h2);
        chk_period(IX_LOCAL, 32);
        axi_wr(OFS_LOCAL_CLK_RATIO, 32'h3);
        chk_period(IX_LOCAL, 32);
    endtask
    task automatic sc_bus_outputs();
        cmp(32'(bdrv), 32'h0, "drive reset");
        axi_wr(OFS_OUTPUT_CLK_CTRL, 32'h5);
        axi_rd(OFS_OUTPUT_CLK_CTRL, 32'h5, RESP_OKAY);
        cmp(32'(bdrv), 32'h5, "drive");
        chk_period(IX_BOUT, 4);
        chk_period(IX_BOUT + 2, 4);
        chk_low(IX_BOUT + 1);
    endtask
    task automatic sc_full_rate();
        do_reset(1'b1, 1'b0, 1'b1);
        chk_period(IX_SYNC, 2);
        chk_period(IX_LOCAL, 4);
    endtask
    task automatic sc_agent();
        do_reset(1'b0, 1'b1, 1'b0);
        axi_wr(OFS_OUTPUT_CLK_CTRL, 32'h7);
        cmp(32'(bdrv), 32'h0, "agent drive");
        chk_period(IX_PCIE, 72);
        chk_period(IX_I2C2, 24);
        chk_low(IX_SYNC);
    endtask
    initial begin
        sc_host_defaults();
        sc_unit_modes();
        sc_bus_outputs();
        sc_full_rate();
        sc_agent();
        tally_and_finish();
    end
endmodule
`default_nettype wire
